//--- include/sbs_pkg.sv
// Shared constants for the southbridge system-management sequencer.
package sbs_pkg;
  localparam logic [3:0] CMD_CLK_HALT     = 4'h3;
  localparam logic [3:0] CMD_HALT_ACK     = 4'h6;
  localparam logic [3:0] CMD_VF_CHANGE    = 4'h7;
  localparam logic [3:0] CMD_MGMT_ACK     = 4'hA;
  localparam int         ASSERT_BIT       = 0;
  localparam logic [2:0] CODE_THROTTLE    = 3'h1;
  localparam logic [2:0] CODE_VF          = 3'h2;
  localparam logic [2:0] CODE_C3          = 3'h3;
  localparam int         CLK_MHZ          = 40;
  localparam int         HALT_US_MIN      = 1;
  localparam int         HALT_US_MAX      = 100;
  localparam int         HALT_CYC_PER_US  = CLK_MHZ;
  localparam int         HALT_CNT_W       = 13;
  localparam logic [6:0] HALT_US_RESET    = 7'h0A;
  localparam int         UNIT_W           = 5;
  localparam logic [4:0] MGMT_UNIT_RESET  = 5'h00;
endpackage

//--- src/sbs_sequencer.sv
// Southbridge system-management sequencer with link-side wake-request handling.
`timescale 1ns/1ps
`default_nettype none
module sbs_sequencer
(
  input  wire logic       sys_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       link_clk_i,
  input  wire logic       init_msg_i,
  input  wire logic       host_enable_i,
  input  wire logic [6:0] halt_time_us_i,
  input  wire logic       dn_valid_i,
  input  wire logic [7:0] dn_code_i,
  input  wire logic       np_req_i,
  input  wire logic [2:0] np_code_i,
  input  wire logic       np_irq_i,
  input  wire logic [4:0] np_unit_i,
  input  wire logic       throttle_req_i,
  input  wire logic       c3_req_i,
  input  wire logic       irq_req_i,
  input  wire logic       up_ready_i,
  input  wire logic       link_wake_request_n_i,
  input  wire logic       own_wake_i,
  output logic            link_wake_request_n_o,
  output logic            link_wake_request_n_oe_o,
  output logic            link_halt_n_o,
  output logic            up_valid_o,
  output logic [7:0]      up_code_o,
  output logic [4:0]      up_unit_o,
  output logic            up_is_irq_o,
  output logic            up_is_resp_o,
  output logic            pass_posted_flag_o,
  output logic            bus_master_activity_flag_o,
  output logic            cpu_in_c3_o,
  output logic            np_busy_o
);
  typedef enum logic [6:0]
  {
    ST_IDLE   = 7'b000_0001,
    ST_SEND   = 7'b000_0010,
    ST_WAIT   = 7'b000_0100,
    ST_HALT   = 7'b000_1000,
    ST_RESP   = 7'b001_0000,
    ST_DEASS  = 7'b010_0000,
    ST_REISS  = 7'b100_0000
  } sbs_state_e;

  sbs_state_e           state;
  logic [2:0]           cur_code;
  logic                 throttle_pending;
  logic                 resp_pend;
  logic                 irq_pend;
  logic [4:0]           resp_unit;
  logic                 posted_pend;
  logic                 mgmt_outstanding;
  logic                 up_enable;
  logic [12:0]          halt_cnt;
  logic                 wake_sync;
  logic                 link_wake_drive;
  logic                 up_fire;
  logic                 dn_ack;
  logic                 dn_vf;
  logic                 dn_mgmt;
  logic [12:0]          halt_cycles;

  function automatic logic is_cmd(input logic [7:0] code, input logic [3:0] cmd);
    is_cmd = (code[7:4] == cmd);
  endfunction

  function automatic logic [7:0] halt_msg(input logic [2:0] sub, input logic lvl);
    halt_msg = {sbs_pkg::CMD_CLK_HALT, sub, lvl};
  endfunction

  assign dn_ack  = dn_valid_i && is_cmd(dn_code_i, sbs_pkg::CMD_HALT_ACK);
  assign dn_vf   = dn_valid_i && is_cmd(dn_code_i, sbs_pkg::CMD_VF_CHANGE);
  assign dn_mgmt = dn_valid_i && is_cmd(dn_code_i, sbs_pkg::CMD_MGMT_ACK) && dn_code_i[sbs_pkg::ASSERT_BIT];
  assign up_fire = up_valid_o && up_ready_i;
  assign np_busy_o = resp_pend;

  // Halt time in cycles, clamped to the supported window.
  always_comb
  begin
    if (halt_time_us_i < 7'(sbs_pkg::HALT_US_MIN))
    begin
      halt_cycles = 13'(sbs_pkg::HALT_US_MIN * sbs_pkg::HALT_CYC_PER_US);
    end
    else if (halt_time_us_i > 7'(sbs_pkg::HALT_US_MAX))
    begin
      halt_cycles = 13'(sbs_pkg::HALT_US_MAX * sbs_pkg::HALT_CYC_PER_US);
    end
    else
    begin
      halt_cycles = 13'(halt_time_us_i * 13'(sbs_pkg::HALT_CYC_PER_US));
    end
  end

  // Link-side open-drain wake: this device only pulls low for its own traffic.
  always_ff @(posedge link_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      link_wake_drive <= 1'b0;
    end
    else
    begin
      link_wake_drive <= own_wake_i;
    end
  end

  assign link_wake_request_n_o    = 1'b0;
  assign link_wake_request_n_oe_o = link_wake_drive;

  sbs_sync #(.RESET_VAL(1'b0)) u_wake_sync
  (
    .clk_i   (sys_clk_i),
    .rst_n_i (rst_n_i),
    .d_i     (~link_wake_request_n_i),
    .q_o     (wake_sync)
  );

  // Upstream gating after reset or init.
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      up_enable <= 1'b0;
    end
    else if (host_enable_i)
    begin
      up_enable <= 1'b1;
    end
    else if (init_msg_i)
    begin
      up_enable <= 1'b0;
    end
  end

  // Activity flag and processor C-state.
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      bus_master_activity_flag_o <= 1'b0;
      cpu_in_c3_o                <= 1'b0;
    end
    else
    begin
      if (wake_sync)
      begin
        bus_master_activity_flag_o <= 1'b1;
      end
      cpu_in_c3_o <= !wake_sync && state == ST_HALT && cur_code == sbs_pkg::CODE_C3;
    end
  end

  // One management interrupt outstanding; first acknowledge clears it.
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      mgmt_outstanding <= 1'b0;
    end
    else if (up_fire && up_is_irq_o)
    begin
      mgmt_outstanding <= 1'b1;
    end
    else if (dn_mgmt)
    begin
      mgmt_outstanding <= 1'b0;
    end
  end

  // Nonposted host accesses awaiting message and response.
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      resp_pend <= 1'b0;
      irq_pend  <= 1'b0;
      resp_unit <= sbs_pkg::MGMT_UNIT_RESET;
    end
    else if (np_req_i && !resp_pend)
    begin
      resp_pend <= 1'b1;
      irq_pend  <= np_irq_i;
      resp_unit <= np_unit_i;
    end
    else
    begin
      if (up_fire && up_is_irq_o)
      begin
        irq_pend <= 1'b0;
      end
      if (up_fire && up_is_resp_o)
      begin
        resp_pend <= 1'b0;
      end
    end
  end

  // Main halt sequence.
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state            <= ST_IDLE;
      cur_code         <= 3'h0;
      throttle_pending <= 1'b0;
      posted_pend      <= 1'b0;
      halt_cnt         <= 13'h0000;
      link_halt_n_o    <= 1'b1;
    end
    else
    begin
      if (dn_vf && state != ST_IDLE)
      begin
        posted_pend <= 1'b1;
      end
      case (state)
        ST_IDLE:
        begin
          if (np_req_i && !resp_pend && np_code_i != 3'h0)
          begin
            cur_code <= np_code_i;
            state    <= ST_SEND;
          end
          else if (dn_vf || posted_pend)
          begin
            posted_pend <= 1'b0;
            cur_code    <= sbs_pkg::CODE_VF;
            state       <= ST_SEND;
          end
          else if (c3_req_i)
          begin
            cur_code <= sbs_pkg::CODE_C3;
            state    <= ST_SEND;
          end
          else if (throttle_req_i)
          begin
            cur_code <= sbs_pkg::CODE_THROTTLE;
            state    <= ST_SEND;
          end
        end
        ST_SEND:
        begin
          if (up_fire && !up_is_resp_o && !up_is_irq_o)
          begin
            throttle_pending <= (cur_code == sbs_pkg::CODE_THROTTLE);
            state            <= ST_WAIT;
          end
        end
        ST_WAIT:
        begin
          if (np_req_i && !resp_pend && throttle_pending && np_code_i != 3'h0)
          begin
            cur_code         <= np_code_i;
            throttle_pending <= 1'b0;
            state            <= ST_SEND;
          end
          else if (dn_ack)
          begin
            throttle_pending <= 1'b0;
            if (throttle_pending && posted_pend)
            begin
              state <= ST_DEASS;
            end
            else if (cur_code == sbs_pkg::CODE_THROTTLE)
            begin
              state <= ST_DEASS;
            end
            else
            begin
              halt_cnt      <= (cur_code == sbs_pkg::CODE_VF) ? halt_cycles : 13'h0000;
              link_halt_n_o <= 1'b0;
              state         <= ST_HALT;
            end
          end
        end
        ST_HALT:
        begin
          if (wake_sync)
          begin
            link_halt_n_o <= 1'b1;
            state         <= ST_DEASS;
          end
          else if (cur_code == sbs_pkg::CODE_VF && halt_cnt == 13'h0000)
          begin
            link_halt_n_o <= 1'b1;
            state         <= ST_DEASS;
          end
          else if (cur_code != sbs_pkg::CODE_VF && !c3_req_i)
          begin
            link_halt_n_o <= 1'b1;
            state         <= ST_DEASS;
          end
          else if (halt_cnt != 13'h0000)
          begin
            halt_cnt <= halt_cnt - 13'h0001;
          end
        end
        ST_DEASS:
        begin
          if (up_fire && !up_is_resp_o && !up_is_irq_o)
          begin
            if (posted_pend)
            begin
              posted_pend <= dn_vf;
              cur_code    <= sbs_pkg::CODE_VF;
              state       <= ST_SEND;
            end
            else
            begin
              state <= ST_IDLE;
            end
          end
        end
        default:
        begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Upstream arbiter: interrupt, then halt message, then response.
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      up_valid_o         <= 1'b0;
      up_code_o          <= 8'h00;
      up_unit_o          <= sbs_pkg::MGMT_UNIT_RESET;
      up_is_irq_o        <= 1'b0;
      up_is_resp_o       <= 1'b0;
      pass_posted_flag_o <= 1'b0;
    end
    else if (!up_valid_o || up_fire)
    begin
      up_valid_o   <= 1'b0;
      up_is_irq_o  <= 1'b0;
      up_is_resp_o <= 1'b0;
      if (up_enable && !up_fire)
      begin
        if ((irq_pend || irq_req_i) && !mgmt_outstanding)
        begin
          up_valid_o  <= 1'b1;
          up_is_irq_o <= 1'b1;
          up_code_o   <= 8'h00;
          up_unit_o   <= resp_unit;
        end
        else if (state == ST_SEND || state == ST_DEASS)
        begin
          up_valid_o <= 1'b1;
          up_code_o  <= halt_msg(cur_code, state == ST_SEND);
          up_unit_o  <= resp_unit;
        end
        else if (resp_pend && !irq_pend && state != ST_SEND)
        begin
          up_valid_o         <= 1'b1;
          up_is_resp_o       <= 1'b1;
          up_unit_o          <= resp_unit;
          pass_posted_flag_o <= 1'b0;
        end
      end
    end
  end

  chk_halt_after_ack : assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (up_valid_o && up_code_o[7:4] == sbs_pkg::CMD_CLK_HALT && !up_code_o[0] && !up_is_irq_o && !up_is_resp_o)
    |-> state == ST_DEASS)
    else $error("Halt deassert sent outside deassert phase.");
  chk_resp_pass_clear : assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    up_valid_o && up_is_resp_o |-> !pass_posted_flag_o)
    else $error("Response left pass-posted set.");
  chk_no_up_disabled : assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !up_enable && $past(!up_enable) |-> !up_valid_o)
    else $error("Upstream message while disabled.");
  chk_one_mgmt_irq : assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    up_valid_o && up_is_irq_o |-> !mgmt_outstanding)
    else $error("Second interrupt before acknowledge.");
  chk_wake_flag : assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    wake_sync |=> bus_master_activity_flag_o && !cpu_in_c3_o)
    else $error("Wake did not set activity flag.");
  chk_wake_release : assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    wake_sync && state == ST_HALT |=> link_halt_n_o)
    else $error("Link halt not released on wake.");
  chk_od_low_only : assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    link_wake_request_n_o == 1'b0)
    else $error("Wake line driven high.");
  chk_resp_after_irq : assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    up_valid_o && up_is_resp_o |-> !irq_pend)
    else $error("Response before pending interrupt.");
  cov_vf_halt : cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    state == ST_HALT && cur_code == sbs_pkg::CODE_VF);
  cov_np_race : cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    state == ST_WAIT && throttle_pending ##1 state == ST_SEND);
  cov_wake : cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    state == ST_HALT && wake_sync);
endmodule
`default_nettype wire

//--- src/sbs_sync.sv
// Two-flop synchroniser for single-bit levels.
`timescale 1ns/1ps
`default_nettype none
module sbs_sync
#(
  parameter logic RESET_VAL = 1'b0
)
(
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic d_i,
  output var  logic q_o
);
  logic meta;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta <= RESET_VAL;
      q_o  <= RESET_VAL;
    end
    else
    begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule
`default_nettype wire

//--- testbench/sbs_host_model.sv
// Host bridge model that accepts upstream items and answers with downstream messages.
`timescale 1ns/1ps
`default_nettype none
module sbs_host_model
(
  input  wire logic       sys_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       up_valid_i,
  input  wire logic [7:0] up_code_i,
  input  wire logic [4:0] up_unit_i,
  input  wire logic       up_is_irq_i,
  input  wire logic       up_is_resp_i,
  input  wire logic       pass_posted_i,
  input  wire logic       np_sent_i,
  input  wire logic       slow_i,
  input  wire logic       hold_i,
  output logic            up_ready_o,
  output logic            dn_valid_o,
  output logic [7:0]      dn_code_o
);
  logic [15:0] log_q[$];
  logic [7:0]  dq[$];
  logic        tick;
  logic        np_pend;
  logic        ack_due;
  logic        mack_due;
  logic [2:0]  ack_code;
  logic        take;
  assign up_ready_o = !slow_i || tick;
  assign take       = up_valid_i && up_ready_o;
  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      tick       <= 1'b0;
      np_pend    <= 1'b0;
      ack_due    <= 1'b0;
      mack_due   <= 1'b0;
      ack_code   <= 3'h0;
      dn_valid_o <= 1'b0;
      dn_code_o  <= 8'h00;
    end
    else
    begin
      tick <= !tick;
      if (np_sent_i)
        np_pend <= 1'b1;
      if (take)
      begin
        log_q.push_back({up_is_irq_i, up_is_resp_i, pass_posted_i, up_unit_i, up_code_i});
        if (up_is_resp_i)
          np_pend <= 1'b0;
        if (up_is_irq_i)
          mack_due <= 1'b1;
        else if (!up_is_resp_i && up_code_i[7:4] == sbs_pkg::CMD_CLK_HALT && up_code_i[sbs_pkg::ASSERT_BIT])
        begin
          ack_due  <= 1'b1;
          ack_code <= up_code_i[3:1];
        end
      end
      if (mack_due && !hold_i)
      begin
        dq.push_back({sbs_pkg::CMD_MGMT_ACK, 4'h1});
        dq.push_back({sbs_pkg::CMD_MGMT_ACK, 4'h1});
        mack_due <= 1'b0;
      end
      if (ack_due && !np_pend && !hold_i)
      begin
        dq.push_back({sbs_pkg::CMD_HALT_ACK, ack_code, 1'b0});
        ack_due <= 1'b0;
      end
      if (dq.size() > 0)
      begin
        dn_valid_o <= 1'b1;
        dn_code_o  <= dq.pop_front();
      end
      else
      begin
        dn_valid_o <= 1'b0;
        dn_code_o  <= ~dn_code_o;
      end
    end
  end
endmodule
`default_nettype wire

//--- testbench/tb.sv
// Self-checking testbench for the system-management sequencer.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin miscompares++; $display("BAD %s exp %0h got %0h", n, e, s); end end
module tb;
  logic        sys_clk = 1'b0;
  logic        link_clk = 1'b0;
  logic        rst_n, init_msg, host_en, np_req, np_irq, throttle, c3, irq, own_wake, tb_pull, slow, hold;
  logic [6:0]  halt_us;
  logic [2:0]  np_code;
  logic [4:0]  np_unit, up_unit;
  logic [7:0]  up_code, dn_code;
  logic        wake_od, wake_oe, wake_wire, halt_n, up_valid, up_irq, up_resp, pp, bm_flag, in_c3, np_busy;
  logic        up_ready, dn_valid;
  int          miscompares = 0;
  int          num_checks = 0;
  localparam logic [15:0] MC = 16'hC0FF;
  localparam logic [15:0] MR = 16'h4000;
  localparam logic [15:0] MI = 16'h8000;
  assign wake_wire = (wake_oe ? wake_od : 1'b1) && !tb_pull;
  always #12.5 sys_clk = ~sys_clk;
  initial
  begin
    #4;
    forever #15 link_clk = ~link_clk;
  end
  sbs_sequencer u_sbs_sequencer (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .link_clk_i(link_clk), .init_msg_i(init_msg),
    .host_enable_i(host_en), .halt_time_us_i(halt_us), .dn_valid_i(dn_valid), .dn_code_i(dn_code), .np_req_i(np_req),
    .np_code_i(np_code), .np_irq_i(np_irq), .np_unit_i(np_unit), .throttle_req_i(throttle), .c3_req_i(c3),
    .irq_req_i(irq), .up_ready_i(up_ready), .link_wake_request_n_i(wake_wire), .own_wake_i(own_wake),
    .link_wake_request_n_o(wake_od), .link_wake_request_n_oe_o(wake_oe), .link_halt_n_o(halt_n),
    .up_valid_o(up_valid), .up_code_o(up_code), .up_unit_o(up_unit), .up_is_irq_o(up_irq), .up_is_resp_o(up_resp),
    .pass_posted_flag_o(pp), .bus_master_activity_flag_o(bm_flag), .cpu_in_c3_o(in_c3), .np_busy_o(np_busy));
  sbs_host_model u_sbs_host_model (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .up_valid_i(up_valid), .up_code_i(up_code),
    .up_unit_i(up_unit), .up_is_irq_i(up_irq), .up_is_resp_i(up_resp), .pass_posted_i(pp), .np_sent_i(np_req),
    .slow_i(slow), .hold_i(hold), .up_ready_o(up_ready), .dn_valid_o(dn_valid), .dn_code_o(dn_code));

  task automatic final_report();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic give_up(input logic timed_out, input string what);
    if (timed_out)
    begin
      miscompares++;
      $display("BAD %s exp done got timeout", what);
      final_report();
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  function automatic int pos(input logic [15:0] m, input logic [15:0] v);
    for (int i = 0; i < u_sbs_host_model.log_q.size(); i++)
      if ((u_sbs_host_model.log_q[i] & m) === v)
        return i;
    return 99;
  endfunction

  function automatic logic [15:0] hc(input logic [2:0] c, input logic a);
    return {8'h00, sbs_pkg::CMD_CLK_HALT, c, a};
  endfunction

  task automatic wait_pos(input logic [15:0] m, input logic [15:0] v);
    int k;
    for (k = 0; k < 300 && pos(m, v) == 99; k++)
      step(1);
    if (k == 300)
    begin
      miscompares++;
      $display("BAD wait exp %0h got none", v);
      final_report();
    end
  endtask

  task automatic np(input logic [2:0] c, input logic q, input logic [4:0] u);
    for (int k = 0; k < 100 && np_busy !== 1'b0; k++)
      step(1);
    give_up(np_busy !== 1'b0, "np_idle");
    u_sbs_host_model.log_q.delete();
    np_code = c;
    np_irq = q;
    np_unit = u;
    np_req = 1'b1;
    step(1);
    np_req = 1'b0;
  endtask

  task automatic run_vf(input int us);
    int n;
    int e;
    e = us * sbs_pkg::HALT_CYC_PER_US;
    for (n = 0; n < 300 && halt_n; n++)
      step(1);
    `CHK("halt_low", 1'b0, halt_n)
    give_up(n == 300, "halt_start");
    for (n = 0; n < 9000 && !halt_n; n++)
      step(1);
    give_up(n == 9000, "halt_end");
    `CHK("halt_len", 1'b1, n >= e && n <= e + 2)
    wait_pos(MC, hc(sbs_pkg::CODE_VF, 1'b0));
  endtask

  task automatic t_reset();
    `CHK("up_valid", 1'b0, up_valid)
    `CHK("halt_n", 1'b1, halt_n)
    `CHK("wake_oe", 1'b0, wake_oe)
    `CHK("in_c3", 1'b0, in_c3)
    `CHK("bm_flag", 1'b0, bm_flag)
  endtask

  task automatic t_enable();
    hold = 1'b1;
    irq = 1'b1;
    step(20);
    `CHK("early", 0, u_sbs_host_model.log_q.size())
    host_en = 1'b1;
    step(1);
    host_en = 1'b0;
    wait_pos(MI, MI);
    step(30);
    `CHK("irq_count", 1, u_sbs_host_model.log_q.size())
    hold = 1'b0;
    irq = 1'b0;
    step(20);
    init_msg = 1'b1;
    step(1);
    init_msg = 1'b0;
    u_sbs_host_model.log_q.delete();
    irq = 1'b1;
    step(20);
    `CHK("after_init", 0, u_sbs_host_model.log_q.size())
    host_en = 1'b1;
    step(1);
    host_en = 1'b0;
    wait_pos(MI, MI);
    irq = 1'b0;
    step(20);
  endtask

  task automatic t_change();
    u_sbs_host_model.log_q.delete();
    u_sbs_host_model.dq.push_back({sbs_pkg::CMD_VF_CHANGE, 4'h0});
    wait_pos(MC, hc(sbs_pkg::CODE_VF, 1'b1));
    run_vf(sbs_pkg::HALT_US_MIN);
  endtask

  task automatic t_np_vf();
    int a;
    int r;
    halt_us = 7'h7F;
    slow = 1'b1;
    np(sbs_pkg::CODE_VF, 1'b0, 5'h05);
    wait_pos(MR, MR);
    a = pos(MC, hc(sbs_pkg::CODE_VF, 1'b1));
    r = pos(MR, MR);
    `CHK("halt_first", 1'b1, a < r)
    `CHK("unit", 5'h05, u_sbs_host_model.log_q[a][12:8])
    `CHK("resp_pp", 1'b0, u_sbs_host_model.log_q[r][13])
    run_vf(sbs_pkg::HALT_US_MAX);
    slow = 1'b0;
    halt_us = 7'h01;
  endtask

  task automatic t_np_irq();
    int q;
    np(3'h0, 1'b1, 5'h09);
    wait_pos(MR, MR);
    q = pos(MI, MI);
    `CHK("irq_first", 1'b1, q < pos(MR, MR))
    `CHK("irq_unit", 5'h09, u_sbs_host_model.log_q[q][12:8])
    step(20);
  endtask

  task automatic t_race_np();
    hold = 1'b1;
    throttle = 1'b1;
    wait_pos(MC, hc(sbs_pkg::CODE_THROTTLE, 1'b1));
    np(sbs_pkg::CODE_VF, 1'b0, 5'h07);
    wait_pos(MR, MR);
    `CHK("second_halt", 1'b1, pos(MC, hc(sbs_pkg::CODE_VF, 1'b1)) < pos(MR, MR))
    throttle = 1'b0;
    hold = 1'b0;
    run_vf(1);
    step(20);
  endtask

  task automatic t_race_posted();
    u_sbs_host_model.log_q.delete();
    hold = 1'b1;
    throttle = 1'b1;
    wait_pos(MC, hc(sbs_pkg::CODE_THROTTLE, 1'b1));
    u_sbs_host_model.dq.push_back({sbs_pkg::CMD_VF_CHANGE, 4'h0});
    step(40);
    `CHK("no_early_msg", 1, u_sbs_host_model.log_q.size())
    hold = 1'b0;
    wait_pos(MC, hc(sbs_pkg::CODE_VF, 1'b1));
    throttle = 1'b0;
    `CHK("deassert_first", 1'b1, pos(MC, hc(sbs_pkg::CODE_THROTTLE, 1'b0)) < pos(MC, hc(sbs_pkg::CODE_VF, 1'b1)))
    run_vf(1);
    step(20);
  endtask

  task automatic t_wake();
    int k;
    c3 = 1'b1;
    for (k = 0; k < 300 && halt_n; k++)
      step(1);
    give_up(k == 300, "c3_halt");
    step(1);
    `CHK("c3_enter", 1'b1, in_c3)
    `CHK("flag_before", 1'b0, bm_flag)
    tb_pull = 1'b1;
    for (k = 0; k < 20 && !halt_n; k++)
      step(1);
    give_up(k == 20, "wake_release");
    step(2);
    `CHK("wake_halt", 1'b1, halt_n)
    `CHK("wake_c0", 1'b0, in_c3)
    `CHK("wake_flag", 1'b1, bm_flag)
    tb_pull = 1'b0;
    c3 = 1'b0;
    step(50);
    @(posedge link_clk);
    #1 own_wake = 1'b1;
    step(10);
    `CHK("own_pull", 1'b1, wake_oe)
    `CHK("pull_low", 1'b0, wake_od)
    @(posedge link_clk);
    #1 own_wake = 1'b0;
    step(10);
    `CHK("own_free", 1'b0, wake_oe)
    `CHK("flag_sticky", 1'b1, bm_flag)
  endtask

  initial
  begin
    {rst_n, init_msg, host_en, np_req, np_irq, throttle, c3, irq, own_wake, tb_pull, slow, hold} = '0;
    halt_us = 7'h00;
    np_code = 3'h0;
    np_unit = 5'h00;
    step(4);
    rst_n = 1'b1;
    t_reset();
    t_enable();
    t_change();
    t_np_vf();
    t_np_irq();
    t_race_np();
    t_race_posted();
    t_wake();
    final_report();
  end
endmodule
`default_nettype wire
